// ===== rtl/qsf_defs.vh
// Purpose: Shared constants of the quad serial flash device front end.
// Assumes: Included by bare name from the design file.
// Notes: Opcode values are free choices of this model.
`ifndef QSF_DEFS_VH
`define QSF_DEFS_VH
// Opcodes.
`define QSF_OP_WREN   8'h06
`define QSF_OP_RDSR   8'h05
`define QSF_OP_READ   8'h03
`define QSF_OP_WRAP   8'h0c
`define QSF_OP_PP     8'h02
`define QSF_OP_SE     8'h20
`define QSF_OP_BE     8'hd8
`define QSF_OP_CE     8'hc7
`define QSF_OP_SUSP   8'hb0
`define QSF_OP_RES    8'h30
`define QSF_OP_QEN    8'h38
`define QSF_OP_QRST   8'hff
`define QSF_OP_BURST  8'hc0
`define QSF_OP_WPROT  8'h42
`define QSF_OP_SECRD  8'h88
`define QSF_OP_SECPG  8'ha5
// Status bit positions.
`define QSF_ST_BUSY   0
`define QSF_ST_WEL    1
`define QSF_ST_SUSP   2
`define QSF_ST_QUAD   7
// Erase unit offset masks over a 22-bit byte address.
`define QSF_M_SECT    22'h00_0fff
`define QSF_M_P8K     22'h00_1fff
`define QSF_M_B32K    22'h00_7fff
`define QSF_M_B64K    22'h00_ffff
`define QSF_M_ALL     22'h3f_ffff
// Timing and sizes.
`define QSF_BUSY_CYC  64
`define QSF_MEM_AW    8
`define QSF_UID       64'h0123_4567_89ab_cdef
`endif

// ===== rtl/qsf_device.v
// Purpose: Pin-level front end of a quad serial flash, with a small array.
// Assumes: Pins arrive asynchronously and are sampled by clock (125 MHz).
// Notes: Only the low 2**MEM_AW bytes are stored; higher addresses alias.
// Contract
// - Input bits are taken on rising serial clock, output shifts after falling.
// - A command starts only after a falling chip select.
// - The quad enable command moves commands, address and data to four bits.
// - After reset input uses line zero and output uses line one.
// - Write-protect pin, pin enable and config bit gate protect writes.
// - Pause pin stops the link while selected, outside quad mode.
// - Ordered variant decides whether pause/protect pins or upper lines are live.
// - Page program takes up to 256 bytes, single or quad width.
// - Reads run linear or wrap within 8, 16, 32 or 64 bytes.
// - A busy status bit shows program or erase in progress.
// - Erase by 4K sector, 8K parameter in the 32K ends, 64K block, or all.
// - Program or erase can be suspended for other areas, then resumed.
// - Security area holds a 64-bit fixed identifier and a user area.
// - Top and bottom parameter blocks can be read-locked.
// - Serial clock may idle low or high between transfers.
`timescale 1ns/1ps
`include "qsf_defs.vh"

module qsf_device #(
	parameter        VARIANT_QUAD = 0,
	parameter        MEM_AW       = `QSF_MEM_AW,
	parameter [15:0] BUSY_CYC     = `QSF_BUSY_CYC,
	parameter [63:0] UID          = `QSF_UID
) (
	input  wire       clock,
	input  wire       nrst,
	input  wire       sck,
	input  wire       cs_n,
	input  wire [3:0] bidir_data_lines_in,
	input  wire       wp_n,
	input  wire       pause_n,
	input  wire       protect_pin_enable,
	input  wire       io_config_bit,
	input  wire       rd_lock_top,
	input  wire       rd_lock_bot,
	output reg  [3:0] bidir_data_lines_out,
	output reg  [3:0] bidir_data_lines_oe,
	output reg        busy,
	output reg        quad_mode,
	output reg  [1:0] wlock
);

	localparam [2:0] PH_IDLE = 3'h0;
	localparam [2:0] PH_CMD  = 3'h1;
	localparam [2:0] PH_ADDR = 3'h2;
	localparam [2:0] PH_DIN  = 3'h3;
	localparam [2:0] PH_DOUT = 3'h4;
	localparam [2:0] PH_SKIP = 3'h5;

	// Returns {top, bottom} when the address lies in a 32K end zone.
	function [1:0] qsf_zone;
		input [21:0] a;
		begin
			qsf_zone = {&a[21:15], ~|a[21:15]};
		end
	endfunction

	// Erase unit size as an offset mask for an opcode and address.
	function [21:0] qsf_emask;
		input [7:0]  op;
		input [21:0] a;
		begin
			if (op == `QSF_OP_SE)
				qsf_emask = `QSF_M_SECT;
			else if (op == `QSF_OP_CE)
				qsf_emask = `QSF_M_ALL;
			else if (qsf_zone(a) == 2'h0)
				qsf_emask = `QSF_M_B64K;
			else if (a[15] == a[21])
				qsf_emask = `QSF_M_P8K;
			else
				qsf_emask = `QSF_M_B32K;
		end
	endfunction

	reg  [7:0]  s1_r, s2_r, s3_r, f_r;
	reg  [2:0]  ph_r;
	reg  [7:0]  cmd_r, sh_r, osh_r;
	reg  [2:0]  bc_r, oc_r;
	reg  [1:0]  nb_r, wrap_r;
	reg  [23:0] addr_r;
	reg         wel_r, susp_r, bsy_r, pgm_r, epend_r;
	reg  [15:0] bcnt_r;
	reg  [21:0] emask_r, eaddr_r;
	reg  [7:0]  mem [0:(1<<MEM_AW)-1];
	reg  [7:0]  sec_mem [0:7];
	reg  [7:0]  st, tx;
	reg  [23:0] anext;
	integer     i;

	// A pin change counts once the second and third stages agree.
	wire [7:0] f_nxt = (s2_r & s3_r) | (f_r & (s2_r | s3_r));
	wire       sck_rise = f_nxt[0] & ~f_r[0];
	wire       sck_fall = ~f_nxt[0] & f_r[0];
	wire       cs_fall  = ~f_nxt[1] & f_r[1];
	wire       cs_rise  = f_nxt[1] & ~f_r[1];
	wire [3:0] din      = f_nxt[5:2];
	// The quad variant, the config bit or quad mode frees the upper lines and kills the pins.
	wire       upper_on = (VARIANT_QUAD != 0) | io_config_bit | quad_mode;
	wire       hold     = ~f_nxt[1] & ~upper_on & ~f_nxt[7];
	wire       wp_block = ~upper_on & protect_pin_enable & ~f_nxt[6];
	wire [7:0] rx       = quad_mode ? {sh_r[3:0], din} : {sh_r[6:0], din[0]};
	wire       rx_done  = quad_mode ? (bc_r == 3'h1) : (bc_r == 3'h7);
	wire [1:0] zone     = qsf_zone(addr_r[21:0]);
	wire [1:0] az       = qsf_zone({addr_r[13:0], rx});
	wire [21:0] a_new   = {addr_r[13:0], rx};
	wire       active   = bsy_r & ~susp_r;
	// Writes must avoid locked ends and a suspended erase region.
	wire       wr_ok    = wel_r & ~active & ((az & wlock) == 2'h0)
		& ~(epend_r & (((a_new ^ eaddr_r) & ~emask_r) == 22'h00_0000));
	wire [7:0] wmask    = (8'h08 << wrap_r) - 8'h01;
	wire [MEM_AW-1:0] idx = addr_r[MEM_AW-1:0];

	// Read byte source and next address for the running burst.
	always @*
	begin
		st = 8'h00;
		st[`QSF_ST_BUSY] = bsy_r & ~susp_r;
		st[`QSF_ST_WEL] = wel_r;
		st[`QSF_ST_SUSP] = susp_r;
		st[`QSF_ST_QUAD] = quad_mode;
		if (cmd_r == `QSF_OP_RDSR)
			tx = st;
		else if (cmd_r == `QSF_OP_SECRD)
			tx = addr_r[3] ? sec_mem[addr_r[2:0]] : UID[{addr_r[2:0], 3'h0} +: 8];
		else if ((zone & {rd_lock_top, rd_lock_bot}) != 2'h0)
			tx = 8'h00;
		else
			tx = mem[idx];
		if (cmd_r == `QSF_OP_PP)
			anext = {addr_r[23:8], addr_r[7:0] + 8'h01};
		else if (cmd_r == `QSF_OP_WRAP)
			anext = {addr_r[23:8], (addr_r[7:0] & ~wmask) | ((addr_r[7:0] + 8'h01) & wmask)};
		else
			anext = addr_r + 24'h00_0001;
	end

	// Three-stage pin capture; the first stage feeds only the second.
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			s1_r <= 8'hff;
			s2_r <= 8'hff;
			s3_r <= 8'hff;
			f_r  <= 8'hff;
		end
		else
		begin
			s1_r <= {pause_n, wp_n, bidir_data_lines_in, cs_n, sck};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r  <= f_nxt;
		end
	end

	// Command engine, busy timer and array updates.
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			ph_r <= PH_IDLE;
			cmd_r <= 8'h00;
			sh_r <= 8'h00;
			osh_r <= 8'h00;
			bc_r <= 3'h0;
			oc_r <= 3'h0;
			nb_r <= 2'h0;
			wrap_r <= 2'h0;
			addr_r <= 24'h00_0000;
			wel_r <= 1'b0;
			susp_r <= 1'b0;
			bsy_r <= 1'b0;
			pgm_r <= 1'b0;
			epend_r <= 1'b0;
			bcnt_r <= 16'h0000;
			emask_r <= 22'h00_0000;
			eaddr_r <= 22'h00_0000;
			quad_mode <= 1'b0;
			wlock <= 2'h0;
			busy <= 1'b0;
			bidir_data_lines_out <= 4'h0;
			bidir_data_lines_oe <= 4'h0;
		end
		else
		begin
			busy <= bsy_r & ~susp_r;
			// Busy timer freezes while suspended; erase lands when it runs out.
			if (active)
			begin
				if (bcnt_r == 16'h0000)
				begin
					bsy_r <= 1'b0;
					epend_r <= 1'b0;
					for (i = 0; i < (1 << MEM_AW); i = i + 1)
						if (epend_r && (((i[21:0] ^ eaddr_r) & ~emask_r) & ((22'h00_0001 << MEM_AW) - 22'h00_0001)) == 22'h00_0000)
							mem[i] <= 8'hff;
				end
				else
					bcnt_r <= bcnt_r - 16'h0001;
			end
			if (cs_rise)
			begin
				// Any partial command is dropped and the lines float.
				ph_r <= PH_IDLE;
				bidir_data_lines_oe <= 4'h0;
				if (pgm_r)
				begin
					pgm_r <= 1'b0;
					wel_r <= 1'b0;
					bsy_r <= 1'b1;
					bcnt_r <= BUSY_CYC - 16'h0001;
				end
			end
			else if (cs_fall)
			begin
				ph_r <= PH_CMD;
				bc_r <= 3'h0;
				oc_r <= 3'h0;
			end
			else if (hold)
				bidir_data_lines_oe <= 4'h0;
			else if (sck_rise && (ph_r == PH_CMD || ph_r == PH_ADDR || ph_r == PH_DIN))
			begin
				sh_r <= rx;
				bc_r <= rx_done ? 3'h0 : bc_r + 3'h1;
				if (rx_done)
				begin
					case (ph_r)
					PH_CMD:
					begin
						cmd_r <= rx;
						nb_r <= 2'h0;
						ph_r <= PH_SKIP;
						if (rx == `QSF_OP_RDSR)
							ph_r <= PH_DOUT;
						else if (rx == `QSF_OP_SUSP && active)
							susp_r <= 1'b1;
						else if (active)
							ph_r <= PH_SKIP; // Only status and suspend while busy.
						else if (rx == `QSF_OP_RES)
							susp_r <= 1'b0;
						else if (rx == `QSF_OP_WREN)
							wel_r <= 1'b1;
						else if (rx == `QSF_OP_QEN)
							quad_mode <= 1'b1;
						else if (rx == `QSF_OP_QRST)
							quad_mode <= 1'b0;
						else if (rx == `QSF_OP_BURST || rx == `QSF_OP_WPROT)
							ph_r <= PH_DIN;
						else if (rx == `QSF_OP_CE && wel_r && !susp_r && wlock == 2'h0)
						begin
							wel_r <= 1'b0;
							bsy_r <= 1'b1;
							epend_r <= 1'b1;
							emask_r <= `QSF_M_ALL;
							bcnt_r <= BUSY_CYC - 16'h0001;
						end
						else if (rx == `QSF_OP_READ || rx == `QSF_OP_WRAP
							|| rx == `QSF_OP_PP || rx == `QSF_OP_SE || rx == `QSF_OP_BE
							|| rx == `QSF_OP_SECRD || rx == `QSF_OP_SECPG)
							ph_r <= PH_ADDR;
					end
					PH_ADDR:
					begin
						addr_r <= {addr_r[15:0], rx};
						nb_r <= nb_r + 2'h1;
						if (nb_r == 2'h2)
						begin
							ph_r <= PH_SKIP;
							if (cmd_r == `QSF_OP_READ || cmd_r == `QSF_OP_WRAP || cmd_r == `QSF_OP_SECRD)
								ph_r <= PH_DOUT;
							else if ((cmd_r == `QSF_OP_PP || cmd_r == `QSF_OP_SECPG) && wr_ok)
								ph_r <= PH_DIN;
							else if ((cmd_r == `QSF_OP_SE || cmd_r == `QSF_OP_BE) && wr_ok && !susp_r)
							begin
								wel_r <= 1'b0;
								bsy_r <= 1'b1;
								epend_r <= 1'b1;
								eaddr_r <= a_new;
								emask_r <= qsf_emask(cmd_r, a_new);
								bcnt_r <= BUSY_CYC - 16'h0001;
							end
						end
					end
					PH_DIN:
					begin
						if (cmd_r == `QSF_OP_PP)
						begin
							mem[idx] <= mem[idx] & rx;
							addr_r <= anext;
							pgm_r <= 1'b1;
						end
						else if (cmd_r == `QSF_OP_SECPG)
						begin
							if (addr_r[3])
								sec_mem[addr_r[2:0]] <= sec_mem[addr_r[2:0]] & rx;
							addr_r <= anext;
							pgm_r <= 1'b1;
						end
						else if (cmd_r == `QSF_OP_BURST)
						begin
							wrap_r <= rx[1:0];
							ph_r <= PH_SKIP;
						end
						else
						begin
							// Protect register write needs enable, and a released pin while the pin is enabled and the upper lines are off.
							if (wel_r && !wp_block)
							begin
								wlock <= rx[1:0];
								wel_r <= 1'b0;
							end
							ph_r <= PH_SKIP;
						end
					end
					default:
						ph_r <= PH_SKIP;
					endcase
				end
			end
			else if (sck_fall && ph_r == PH_DOUT)
			begin
				// A new byte loads on the first falling edge after the last input bit or after the last bit of the previous byte.
				oc_r <= (quad_mode ? (oc_r == 3'h1) : (oc_r == 3'h7)) ? 3'h0 : oc_r + 3'h1;
				if (oc_r == 3'h0)
				begin
					osh_r <= quad_mode ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
					bidir_data_lines_out <= quad_mode ? tx[7:4] : {2'h0, tx[7], 1'b0};
					if (cmd_r != `QSF_OP_RDSR)
						addr_r <= anext;
				end
				else
				begin
					osh_r <= quad_mode ? {osh_r[3:0], 4'h0} : {osh_r[6:0], 1'b0};
					bidir_data_lines_out <= quad_mode ? osh_r[7:4] : {2'h0, osh_r[7], 1'b0};
				end
				bidir_data_lines_oe <= quad_mode ? 4'hf : 4'h2;
			end
		end
	end

endmodule

// ===== verif/qsf_device_asserts.sv
// Purpose: Port checks of the serial flash front end.
// Assumes: Link pins pass a short flop filter and settle within eight clocks.
// Notes: Bound into every qsf_device instance.
`timescale 1ns/1ps
module qsf_asserts #(
	parameter VARIANT_QUAD = 0
) (
	input wire       clock,
	input wire       nrst,
	input wire       sck,
	input wire       cs_n,
	input wire       pause_n,
	input wire       io_config_bit,
	input wire [3:0] bidir_data_lines_out,
	input wire [3:0] bidir_data_lines_oe,
	input wire       busy,
	input wire       quad_mode,
	input wire [1:0] wlock
);
	// Eight steady clocks outlast the pin filter, so pin levels are settled by then.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_RST_QUIET: assert property (disable iff (1'b0) !nrst |=>
		bidir_data_lines_oe == 4'h0 && !quad_mode && !busy && wlock == 2'b00)
		else $error("outputs active after reset");
	AST_DESELECT_FLOAT: assert property (cs_n[*6] |-> bidir_data_lines_oe == 4'h0)
		else $error("lines driven while deselected");
	AST_SINGLE_LINE: assert property (!quad_mode |-> bidir_data_lines_oe inside {4'h0, 4'h2})
		else $error("single mode drives a wrong line");
	AST_QUAD_LINES: assert property (quad_mode |-> bidir_data_lines_oe inside {4'h0, 4'hf})
		else $error("quad mode drives a partial nibble");
	AST_OUT_HOLD: assert property (sck[*6] |-> $stable(bidir_data_lines_out))
		else $error("output moved while serial clock high");
	AST_PAUSE_FLOAT: assert property (
		(!pause_n && !io_config_bit && !quad_mode && VARIANT_QUAD == 0)[*6]
		|-> bidir_data_lines_oe == 4'h0) else $error("lines driven while paused");
	AST_BUSY_START: assert property (cs_n[*8] |-> !$rose(busy))
		else $error("busy started with no command");
	AST_LOCK_HOLD: assert property (cs_n[*8] |-> $stable(wlock))
		else $error("write lock changed while idle");
	AST_DRIVE_SELECTED: assert property ($rose(bidir_data_lines_oe != 4'h0) |-> !cs_n)
		else $error("drive began without a selection");
endmodule

bind qsf_device qsf_asserts #(.VARIANT_QUAD(VARIANT_QUAD)) i_qsf_asserts (
	.clock(clock), .nrst(nrst), .sck(sck), .cs_n(cs_n), .pause_n(pause_n),
	.io_config_bit(io_config_bit), .bidir_data_lines_out(bidir_data_lines_out),
	.bidir_data_lines_oe(bidir_data_lines_oe), .busy(busy), .quad_mode(quad_mode),
	.wlock(wlock));

// ===== verif/qsf_host.sv
// Purpose: Host controller model that drives the flash link pins.
// Assumes: Half period of 62.5 ns; the bench picks idle level and width.
// Notes: A released line shows the inverse of the last host value.
`timescale 1ns/1ps
module qsf_host (
	input  wire  [3:0] dev_out,
	input  wire  [3:0] dev_oe,
	output logic       sck,
	output logic       cs_n,
	output wire  [3:0] lines
);
	logic [3:0] h_out;
	logic [3:0] h_oe;
	logic       idle;
	logic       quad;
	// Device drive wins; no one driving gives a flipped level, never a stale bit.
	assign lines = (dev_oe & dev_out) | (~dev_oe & (h_out ^ ~h_oe));
	// Pins start deselected with the clock at its idle level.
	initial
	begin
		{sck, cs_n, h_out, h_oe, idle, quad} = {1'b0, 1'b1, 4'h0, 4'h0, 1'b0, 1'b0};
	end
	// Select stays low until stop, so a frame is never cut short.
	task start();
		sck = idle;
		#62.5 cs_n = 1'b0;
		#62.5;
	endtask
	task stop();
		sck = idle;
		h_oe = 4'h0;
		#62.5 cs_n = 1'b1;
		#100;
	endtask
	// Data changes while the clock is low and is read at the rising edge.
	task xfer(input logic [7:0] tx, input logic wr, output logic [7:0] rx);
		for (int i = 0; i < (quad ? 2 : 8); i++)
		begin
			sck = 1'b0;
			h_oe = !wr ? 4'h0 : quad ? 4'hf : 4'h1;
			h_out = quad ? tx[7 - 4 * i -: 4] : {3'b000, tx[7 - i]};
			#62.5 sck = 1'b1;
			rx = quad ? {rx[3:0], lines} : {rx[6:0], lines[1]};
			#62.5;
		end
	endtask
endmodule

// ===== verif/qsf_device_tb_top.sv
// Purpose: Self-checking bench of the serial flash front end.
// Assumes: Bench clock of 8 ns; link half period of 62.5 ns.
// Notes: Erase comes before program because the array powers up unknown.
`timescale 1ns/1ps
`include "qsf_defs.vh"
module qsf_device_tb_top;
	logic       clock;
	logic       nrst;
	logic       wp_n;
	logic       pause_n;
	logic       pin_en;
	logic       rd_lock_bot;
	wire        sck;
	wire        cs_n;
	wire  [3:0] lines;
	wire  [3:0] d_out;
	wire  [3:0] d_oe;
	wire        busy;
	wire        quad_mode;
	wire  [1:0] wlock;
	logic [7:0] r;
	logic [7:0] rd [2];
	logic [63:0] uid = `QSF_UID;
	int         error_cnt;
	int         num_checks;
	// A long busy time lets the status poll see the busy bit set.
	qsf_device #(.BUSY_CYC(16'd400)) i_qsf_device (
		.clock(clock), .nrst(nrst), .sck(sck), .cs_n(cs_n), .bidir_data_lines_in(lines),
		.wp_n(wp_n), .pause_n(pause_n), .protect_pin_enable(pin_en), .io_config_bit(1'b0),
		.rd_lock_top(1'b0), .rd_lock_bot(rd_lock_bot), .bidir_data_lines_out(d_out),
		.bidir_data_lines_oe(d_oe), .busy(busy), .quad_mode(quad_mode), .wlock(wlock));
	qsf_host i_qsf_host (.dev_out(d_out), .dev_oe(d_oe), .sck(sck), .cs_n(cs_n), .lines(lines));
	// Free running system clock.
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One frame: opcode, address bytes, written bytes, then read bytes.
	task frame(input logic [7:0] op, input int na, input logic [23:0] a, input int nw,
		input logic [15:0] w, input int nr);
		i_qsf_host.start();
		i_qsf_host.xfer(op, 1'b1, r);
		for (int i = 0; i < na; i++)
			i_qsf_host.xfer(a[23 - 8 * i -: 8], 1'b1, r);
		for (int i = 0; i < nw; i++)
			i_qsf_host.xfer(w[15 - 8 * i -: 8], 1'b1, r);
		for (int i = 0; i < nr; i++)
		begin
			i_qsf_host.xfer(8'h00, 1'b0, r);
			rd[i] = r;
		end
		i_qsf_host.stop();
	endtask
	// Poll status under a bound; first poll must still show busy.
	task wait_idle();
		for (int k = 0; k < 40; k++)
		begin
			frame(`QSF_OP_RDSR, 0, 24'h0, 0, 16'h0, 1);
			if (k == 0)
				chk("status busy", 8'h01, rd[0] & 8'h01);
			if (rd[0] === 8'h00)
				return;
		end
		error_cnt++;
		end_of_test();
	endtask
	task read2(input logic [7:0] op, input logic [23:0] a, input logic [15:0] e);
		frame(op, 3, a, 0, 16'h0, 2);
		chk("read byte 0", e[15:8], rd[0]);
		chk("read byte 1", e[7:0], rd[1]);
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence of tests.
	initial
	begin
		nrst = 1'b0;
		wp_n = 1'b1;
		pause_n = 1'b1;
		pin_en = 1'b0;
		rd_lock_bot = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (2) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (8) @(posedge clock);
		chk("reset state", 8'h00, {d_oe, busy, quad_mode, wlock});
		frame(`QSF_OP_WREN, 0, 24'h0, 0, 16'h0, 0);
		frame(`QSF_OP_SE, 3, 24'h0, 0, 16'h0, 0);
		chk("busy pin", 8'h01, {7'h0, busy});
		wait_idle();
		frame(`QSF_OP_WREN, 0, 24'h0, 0, 16'h0, 0);
		frame(`QSF_OP_PP, 3, 24'h10, 2, 16'ha53c, 0);
		wait_idle();
		read2(`QSF_OP_READ, 24'h10, 16'ha53c);
		frame(`QSF_OP_BURST, 0, 24'h0, 1, 16'h0000, 0);
		read2(`QSF_OP_WRAP, 24'h17, 16'hffa5);
		i_qsf_host.idle = 1'b1;
		read2(`QSF_OP_READ, 24'h10, 16'ha53c);
		i_qsf_host.idle = 1'b0;
		$display("erase, program and read done");
		frame(`QSF_OP_QEN, 0, 24'h0, 0, 16'h0, 0);
		chk("quad on", 8'h01, {7'h0, quad_mode});
		i_qsf_host.quad = 1'b1;
		read2(`QSF_OP_READ, 24'h10, 16'ha53c);
		frame(`QSF_OP_QRST, 0, 24'h0, 0, 16'h0, 0);
		i_qsf_host.quad = 1'b0;
		chk("quad off", 8'h00, {7'h0, quad_mode});
		rd_lock_bot = 1'b1;
		read2(`QSF_OP_READ, 24'h10, 16'h0000);
		rd_lock_bot = 1'b0;
		$display("quad and read lock done");
		i_qsf_host.start();
		for (int i = 0; i < 5; i++)
			i_qsf_host.xfer(i == 0 ? `QSF_OP_READ : 8'h00, i < 4, r);
		chk("single drive", 8'h02, {4'h0, d_oe});
		pause_n = 1'b0;
		#100;
		chk("paused drive", 8'h00, {4'h0, d_oe});
		pause_n = 1'b1;
		i_qsf_host.stop();
		frame(`QSF_OP_WREN, 0, 24'h0, 0, 16'h0, 0);
		frame(`QSF_OP_WPROT, 0, 24'h0, 1, 16'h0100, 0);
		chk("lock write", 8'h01, {6'h0, wlock});
		{wp_n, pin_en} = 2'b01;
		frame(`QSF_OP_WREN, 0, 24'h0, 0, 16'h0, 0);
		frame(`QSF_OP_WPROT, 0, 24'h0, 1, 16'h0200, 0);
		chk("lock refused", 8'h01, {6'h0, wlock});
		{wp_n, pin_en} = 2'b10;
		$display("pause and protect done");
		// Identifier bytes come out lowest byte first as the address counts up.
		read2(`QSF_OP_SECRD, 24'h0, {uid[7:0], uid[15:8]});
		// Erase in an unlocked middle block, then freeze and resume its timer.
		frame(`QSF_OP_WREN, 0, 24'h0, 0, 16'h0, 0);
		frame(`QSF_OP_SE, 3, 24'h10_0000, 0, 16'h0, 0);
		frame(`QSF_OP_SUSP, 0, 24'h0, 0, 16'h0, 0);
		chk("suspended busy", 8'h00, {7'h0, busy});
		frame(`QSF_OP_RES, 0, 24'h0, 0, 16'h0, 0);
		chk("resumed busy", 8'h01, {7'h0, busy});
		wait_idle();
		$display("suspend and security done");
		end_of_test();
	end
endmodule
